// ### design/burst4_array.sv
// Word array with lane-masked writes and a registered read port.
`timescale 1ns/10ps

module burst4_array (
    input logic clk,
    input logic rst_n,
    mem_if.array m
);
    import burst4_pkg::*;

    typedef struct packed {
        word_t rdata;
    } arr_state_t;

    word_t      mem [MEM_DEPTH];
    arr_state_t s_q;
    arr_state_t s_d;

    // Read data; a write to the same word in the same cycle is seen.
    always_comb begin
        s_d = s_q;
        if (m.re) begin
            s_d.rdata = mem[m.raddr];
            if (m.we && m.waddr == m.raddr) begin
                s_d.rdata = lane_merge(mem[m.raddr], m.wdata, m.wen);
            end
        end
    end

    // Array storage; lanes with a deasserted select keep their bits.
    always_ff @(posedge clk) begin
        if (m.we) begin
            mem[m.waddr] <= lane_merge(mem[m.waddr], m.wdata, m.wen);
        end
    end

    // State register.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign m.rdata = s_q.rdata;

endmodule : burst4_array

// ### design/burst4_buffer.sv
// Two-entry word buffer with valid and ready on both sides.
`timescale 1ns/10ps

module burst4_buffer (
    input logic clk,
    input logic rst_n,
    stream_if.snk fill,
    stream_if.src drain
);
    import burst4_pkg::*;

    typedef struct packed {
        word_t      head;
        word_t      tail;
        logic [1:0] count;
    } buf_state_t;

    buf_state_t s_q;
    buf_state_t s_d;
    logic       push;
    logic       pop;

    // Handshakes; a full buffer refuses the filling side.
    assign fill.ready  = (s_q.count != BUF_FULL);
    assign drain.valid = (s_q.count != 2'h0);
    assign drain.data  = s_q.head;
    assign push        = fill.valid & fill.ready;
    assign pop         = drain.valid & drain.ready;

    // Entry movement: the head leaves first, the tail moves up.
    always_comb begin
        s_d = s_q;
        case ({push, pop})
            2'b10: begin
                if (s_q.count == 2'h0) begin
                    s_d.head = fill.data;
                end else begin
                    s_d.tail = fill.data;
                end
                s_d.count = s_q.count + 2'h1;
            end
            2'b01: begin
                s_d.head  = s_q.tail;
                s_d.count = s_q.count - 2'h1;
            end
            2'b11: begin
                if (s_q.count == 2'h1) begin
                    s_d.head = fill.data;
                end else begin
                    s_d.head = s_q.tail;
                    s_d.tail = fill.data;
                end
            end
            default: begin
                s_d.count = s_q.count;
            end
        endcase
    end

    // State register.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

endmodule : burst4_buffer

// ### design/burst4_ddr_sram_port.sv
// Burst-of-four double data rate SRAM port, sampled by the core clock.
`timescale 1ns/10ps

module burst4_ddr_sram_port (
    input  logic               clk,
    input  logic               rst_n,
    input  logic               in_clk,
    input  logic               in_clk_comp,
    input  logic               out_clk,
    input  logic               out_clk_comp,
    input  logic               single_clock,
    input  logic               pll_bypass_n,
    input  burst4_pkg::addr_t  addr,
    input  logic               read_port_sel_n,
    input  logic               write_port_sel_n,
    input  burst4_pkg::word_t  wdata,
    input  burst4_pkg::lanes_t byte_write_sel_n,
    output burst4_pkg::word_t  rdata,
    output logic               rdata_valid,
    output logic               returned_strobe,
    output logic               returned_strobe_n
);
    import burst4_pkg::*;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------

    // Every pin that arrives from the controller's side.
    typedef struct packed {
        logic   in_clk;
        logic   in_clk_comp;
        logic   out_clk;
        logic   out_clk_comp;
        logic   single;
        logic   pll_on;
        logic   rsel_n;
        logic   wsel_n;
        addr_t  addr;
        word_t  wdata;
        lanes_t bws_n;
    } pins_t;

    // All state of the port.
    typedef struct packed {
        pins_t      s1;          // First synchroniser stage.
        pins_t      s2;          // Second synchroniser stage.
        logic       k_prev;
        logic       kc_prev;
        logic       oc_prev;
        logic       occ_prev;

        logic       wr_slot;     // Next input clock rise takes a write.
        logic       collecting;  // Write burst words still arriving.
        logic [1:0] wr_word;
        addr_t      wr_addr;

        logic       pend;        // Captured read waiting for the fetcher.
        addr_t      pend_addr;
        logic       hazard;      // Pending read must wait for the write.
        fetch_t     fstate;
        addr_t      rd_addr;
        logic [1:0] f_word;
        logic [1:0] arm;         // Output edges until the first word.
        logic [2:0] out_left;    // Words of the burst still to send.

        word_t      rdata;
        logic       rvalid;
        logic       strobe;
        logic       strobe_n;
    } state_t;

    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    state_t s_q;
    state_t s_d;
    pins_t  pins_now;

    logic   k_rise;
    logic   kc_rise;
    logic   oc_level;
    logic   occ_level;
    logic   oc_rise;
    logic   occ_rise;
    logic   out_edge;

    logic   word_evt;
    logic   last_evt;

    logic   due;
    logic   pop;

    stream_if fill ();
    stream_if drain ();
    mem_if    m ();

    // ------------------------------------------------------------------
    // Sub-blocks
    // ------------------------------------------------------------------

    // Array holding four words per location.
    burst4_array u_array (
        .clk   (clk),
        .rst_n (rst_n),
        .m     (m)
    );

    // Buffer between the array and the output register.
    burst4_buffer u_buffer (
        .clk   (clk),
        .rst_n (rst_n),
        .fill  (fill),
        .drain (drain)
    );

    // ------------------------------------------------------------------
    // Pin sampling and edge detection
    // ------------------------------------------------------------------

    // Gather the pins; they all pass the same two stages, so data stays
    // aligned with the clock levels sampled beside it.
    always_comb begin
        pins_now.in_clk       = in_clk;
        pins_now.in_clk_comp  = in_clk_comp;
        pins_now.out_clk      = out_clk;
        pins_now.out_clk_comp = out_clk_comp;

        pins_now.single       = single_clock;
        pins_now.pll_on       = pll_bypass_n;
        pins_now.rsel_n       = read_port_sel_n;
        pins_now.wsel_n       = write_port_sel_n;
        pins_now.addr         = addr;
        pins_now.wdata        = wdata;
        pins_now.bws_n        = byte_write_sel_n;
    end

    // Only rising edges of each clock are used, never a falling one.
    assign k_rise  = rise(s_q.k_prev, s_q.s2.in_clk);
    assign kc_rise = rise(s_q.kc_prev, s_q.s2.in_clk_comp);

    // Output registers follow the output pair, or the input pair when
    // the device runs from a single clock domain.
    assign oc_level  = s_q.s2.single ? s_q.s2.in_clk
                                     : s_q.s2.out_clk;
    assign occ_level = s_q.s2.single ? s_q.s2.in_clk_comp
                                     : s_q.s2.out_clk_comp;

    assign oc_rise   = rise(s_q.oc_prev, oc_level);
    assign occ_rise  = rise(s_q.occ_prev, occ_level);
    assign out_edge  = oc_rise | occ_rise;

    // ------------------------------------------------------------------
    // Write burst words
    // ------------------------------------------------------------------

    // Even words arrive on the complement rise, odd words on the true rise.
    assign word_evt = s_q.collecting &
                      (s_q.wr_word[0] ? k_rise : kc_rise);
    assign last_evt = word_evt & (s_q.wr_word == LAST_WORD);

    // Each word goes straight into the array, self-timed from the clock.
    always_comb begin
        m.we    = word_evt;
        m.waddr = {s_q.wr_addr, s_q.wr_word};
        m.wdata = s_q.s2.wdata;
        m.wen   = ~s_q.s2.bws_n;

        // Read port, driven by the fetcher.
        m.re    = (s_q.fstate == F_ISSUE);
        m.raddr = {s_q.rd_addr, s_q.f_word};
    end

    // ------------------------------------------------------------------
    // Read output scheduling
    // ------------------------------------------------------------------

    // A word is due on the edge that ends the latency and on the three
    // edges that follow it.
    assign due = out_edge & ((s_q.arm == 2'h1) |
                             (s_q.out_left != 3'h0));

    assign pop = due & drain.valid;
    assign drain.ready = due;

    // The fetcher offers one array word at a time to the buffer.
    assign fill.valid = (s_q.fstate == F_PUSH);
    assign fill.data  = m.rdata;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        s_d = s_q;

        // Synchroniser stages and edge history.
        s_d.s1       = pins_now;
        s_d.s2       = s_q.s1;

        s_d.k_prev   = s_q.s2.in_clk;
        s_d.kc_prev  = s_q.s2.in_clk_comp;
        s_d.oc_prev  = oc_level;
        s_d.occ_prev = occ_level;

        // Echo clocks copy the clock that times the read data.
        s_d.strobe   = oc_level;
        s_d.strobe_n = occ_level;

        // Advance through the write burst; the last word ends it.
        if (word_evt) begin
            s_d.wr_word = s_q.wr_word + 2'h1;
        end
        if (last_evt) begin
            s_d.collecting = 1'b0;
            s_d.hazard     = 1'b0;
        end

        // Output side: count down the latency, then send four words.
        if (out_edge) begin
            s_d.rvalid = pop;

            if (s_q.arm != 2'h0) begin
                s_d.arm = s_q.arm - 2'h1;
            end
            if (due && s_q.arm == 2'h1) begin
                s_d.out_left = WORDS_AFTER_1ST;
            end else if (due) begin
                s_d.out_left = s_q.out_left - 3'h1;
            end
        end

        if (pop) begin
            s_d.rdata = drain.data;
        end

        // Input clock rise: alternate between write and read slots.
        if (k_rise) begin
            s_d.wr_slot = ~s_q.wr_slot;

            if (s_q.wr_slot) begin
                if (!s_q.s2.wsel_n) begin
                    s_d.collecting = 1'b1;
                    s_d.wr_word    = 2'h0;
                    s_d.wr_addr    = s_q.s2.addr;
                end
            end else if (!s_q.s2.rsel_n) begin
                // Queue the read and arm its latency.
                s_d.pend      = 1'b1;
                s_d.pend_addr = s_q.s2.addr;
                s_d.arm       = s_q.s2.pll_on ? LAT_PLL_EDGES
                                              : LAT_BYPASS_EDGES;
                // Wait for a write to this location still arriving.
                s_d.hazard    = s_q.collecting & ~last_evt &
                                (s_q.wr_addr == s_q.s2.addr);
            end
        end

        // Fetcher: reads run beside writes on their own array port.
        case (s_q.fstate)
            F_IDLE: begin
                // A clashing write holds the read back.
                if (s_q.pend && !s_q.hazard) begin
                    s_d.pend    = 1'b0;
                    s_d.rd_addr = s_q.pend_addr;
                    s_d.f_word  = 2'h0;
                    s_d.fstate  = F_ISSUE;
                end
            end

            F_ISSUE: begin
                s_d.fstate = F_PUSH;
            end

            F_PUSH: begin
                // Hold the word while the buffer is full.
                if (fill.ready) begin
                    // The last word ends the fetch.
                    if (s_q.f_word == LAST_WORD) begin
                        s_d.fstate = F_IDLE;
                    end else begin
                        s_d.f_word = s_q.f_word + 2'h1;
                        s_d.fstate = F_ISSUE;
                    end
                end
            end

            default: begin
                s_d.fstate = F_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_q         <= '0;
            // The fetcher and slot parity take named values.
            s_q.fstate  <= F_IDLE;
            s_q.wr_slot <= RESET_WR_SLOT;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------

    // Read data come only from the output register; no pin is shared.
    assign rdata             = s_q.rdata;
    assign rdata_valid       = s_q.rvalid;

    // Echo clocks leave with the data they time.
    assign returned_strobe   = s_q.strobe;
    assign returned_strobe_n = s_q.strobe_n;

endmodule : burst4_ddr_sram_port

// ### design/burst4_if.sv
// Interfaces that join the port logic to its buffer and its array.
`timescale 1ns/10ps

// ----------------------------------------------------------------------
// Word stream with valid and ready
// ----------------------------------------------------------------------
interface stream_if;
    logic              valid;
    logic              ready;
    burst4_pkg::word_t data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : stream_if

// ----------------------------------------------------------------------
// Array access: one write port with lane enables, one read port
// ----------------------------------------------------------------------
interface mem_if;
    logic                  we;
    burst4_pkg::mem_addr_t waddr;
    burst4_pkg::word_t     wdata;
    burst4_pkg::lanes_t    wen;
    logic                  re;
    burst4_pkg::mem_addr_t raddr;
    burst4_pkg::word_t     rdata;
    modport ctrl (output we, output waddr, output wdata, output wen,
                  output re, output raddr, input rdata);
    modport array (input we, input waddr, input wdata, input wen,
                   input re, input raddr, output rdata);
endinterface : mem_if

// ### design/burst4_pkg.sv
// Shared constants, types and helper functions of the burst SRAM port.
package burst4_pkg;

    // ------------------------------------------------------------------
    // Data word and byte lane layout
    // ------------------------------------------------------------------
    localparam int WORD_W      = 36;  // Build width, one of 8, 9, 18, 36.
    localparam int LANE_W      = 9;   // Bits guarded by one byte select.
    localparam int LANES       = 4;   // Byte selects per word.
    localparam int BURST_WORDS = 4;   // Words moved per accepted address.

    // ------------------------------------------------------------------
    // Address layout
    // ------------------------------------------------------------------
    localparam int LOC_AW     = 8;    // Burst locations held by the array.
    localparam int WORD_IDX_W = 2;    // Word index inside one burst.
    localparam int MEM_AW     = LOC_AW + WORD_IDX_W;
    localparam int MEM_DEPTH  = 1 << MEM_AW;

    // ------------------------------------------------------------------
    // Timing counts, in edges of the output clock pair
    // ------------------------------------------------------------------
    localparam logic [1:0] LAT_PLL_EDGES    = 2'h3;  // One and a half cycles.
    localparam logic [1:0] LAT_BYPASS_EDGES = 2'h2;  // One cycle.
    localparam logic [1:0] LAST_WORD        = 2'h3;
    localparam logic [2:0] WORDS_AFTER_1ST  = 3'h3;

    // Highest input clock rate the controller may drive, in MHz.
    localparam int LINK_FMAX_MHZ = 333;
    // Rate of the sampling clock, in MHz.
    localparam int CLK_FREQ_MHZ  = 100;

    // ------------------------------------------------------------------
    // Buffer and reset values
    // ------------------------------------------------------------------
    localparam int         BUF_DEPTH     = 2;
    localparam logic [1:0] BUF_FULL      = 2'h2;
    localparam logic       RESET_WR_SLOT = 1'b0;  // First rise is a read slot.

    typedef logic [WORD_W-1:0] word_t;
    typedef logic [LANES-1:0]  lanes_t;
    typedef logic [LOC_AW-1:0] addr_t;
    typedef logic [MEM_AW-1:0] mem_addr_t;

    // Fetch engine states.
    typedef enum logic [2:0] {
        F_IDLE  = 3'b001,
        F_ISSUE = 3'b010,
        F_PUSH  = 3'b100
    } fetch_t;

    // Merge new lanes into an old word wherever the lane is enabled.
    function automatic word_t lane_merge(input word_t  old_w,
                                         input word_t  new_w,
                                         input lanes_t en);
        word_t r;
        r = old_w;
        for (int i = 0; i < LANES; i++) begin
            if (en[i]) begin
                r[i*LANE_W +: LANE_W] = new_w[i*LANE_W +: LANE_W];
            end
        end
        return r;
    endfunction : lane_merge

    // Rising edge of a sampled level.
    function automatic logic rise(input logic prev, input logic now);
        return now & ~prev;
    endfunction : rise

endpackage : burst4_pkg

// ### tb/burst4_ddr_sram_port_tb_top.sv
// Self-checking bench for the burst SRAM port and its controller model.
`timescale 1ns/10ps

module burst4_ddr_sram_port_tb_top;
    import burst4_pkg::*;
    logic   clk, rst_n, single_clock, pll_bypass_n, e_q, s_q, sn_q;
    logic   in_clk, in_clk_comp, out_clk, out_clk_comp;
    logic   read_port_sel_n, write_port_sel_n;
    logic   rdata_valid, returned_strobe, returned_strobe_n;
    addr_t  addr;
    word_t  wdata, rdata;
    lanes_t byte_write_sel_n;
    word_t  shadow[int];
    word_t  got[$];
    int     at[$];
    int     edges, cyc, n_mismatch, check_count;

    burst4_ddr_sram_port u_burst4_ddr_sram_port (
        .clk, .rst_n, .in_clk, .in_clk_comp, .out_clk, .out_clk_comp,
        .single_clock, .pll_bypass_n, .addr, .read_port_sel_n,
        .write_port_sel_n, .wdata, .byte_write_sel_n, .rdata,
        .rdata_valid, .returned_strobe, .returned_strobe_n);
    host_ctrl_model u_host_ctrl_model (
        .clk, .rst_n, .in_clk, .in_clk_comp, .out_clk, .out_clk_comp,
        .addr, .read_port_sel_n, .write_port_sel_n, .wdata,
        .byte_write_sel_n);

    // Free running core clock.
    always #5 clk = ~clk;

    // Takes a read word one cycle after its echo edge.
    always @(negedge clk) begin
        if (e_q && rdata_valid) begin
            got.push_back(rdata);
            at.push_back(edges - 1);
        end
        e_q = (returned_strobe && !s_q) || (returned_strobe_n && !sn_q);
        edges = !rst_n ? 0 : edges + int'(e_q);
        s_q = returned_strobe;
        sn_q = returned_strobe_n;
    end

    // Cuts a hung run short.
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            give_verdict();
        end
    end

    // Counts a comparison and reports a difference.
    task automatic check(input string what, input word_t seen,
                         input word_t exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Runs one access and judges the words read.
    task automatic run_burst(input logic rd, input addr_t ra, input logic wr,
                             input addr_t wa, input word_t base,
                             input logic [15:0] lns, input int lat);
        word_t  w[4];
        lanes_t ln[4];
        got.delete();
        at.delete();
        for (int i = 0; i < 4; i++) begin
            w[i] = base + word_t'(i);
            ln[i] = lns[i*4 +: 4];
            for (int j = 0; j < LANES; j++) begin
                if (wr && !ln[i][j])
                    shadow[int'(wa)*4+i][j*LANE_W +: LANE_W] =
                        w[i][j*LANE_W +: LANE_W];
            end
        end
        u_host_ctrl_model.burst(rd, ra, wr, wa, w, ln);
        repeat (76) @(negedge clk);
        check("word count", word_t'(got.size()), rd ? 36'h4 : 36'h0);
        for (int i = 0; i < got.size() && i < 4; i++)
            check("read word", got[i], shadow[int'(ra)*4+i]);
        if (rd && at.size() > 0)
            check("first edge", word_t'(at[0]),
                  word_t'(2 * u_host_ctrl_model.rd_rise + lat));
    endtask : run_burst

    // Fills a place, then reads it while a new burst is still arriving.
    task automatic sc_fresh;
        run_burst(1'b0, 8'h00, 1'b1, 8'h5a, 36'h1_2345_6780, 16'h0000, 3);
        run_burst(1'b1, 8'h5a, 1'b1, 8'h5a, 36'h9_8765_4320, 16'h0000, 3);
    endtask : sc_fresh

    // Masked write beside a read elsewhere, then a one-cycle read.
    task automatic sc_lanes;
        run_burst(1'b0, 8'h00, 1'b1, 8'hff, 36'ha_aaaa_aaa0, 16'h0000, 3);
        run_burst(1'b1, 8'h5a, 1'b1, 8'hff, 36'h5_5555_5550, 16'hfa50, 3);
        pll_bypass_n = 1'b0;
        single_clock = 1'b1;
        repeat (8) @(negedge clk);
        run_burst(1'b1, 8'hff, 1'b0, 8'h00, 36'h0_0000_0000, 16'hffff, 2);
    endtask : sc_lanes

    // Selects held off bring no words and leave the array alone.
    task automatic sc_idle;
        pll_bypass_n = 1'b1;
        single_clock = 1'b0;
        run_burst(1'b0, 8'h5a, 1'b0, 8'h5a, 36'hf_0f0f_0f00, 16'h0000, 3);
        run_burst(1'b1, 8'h5a, 1'b0, 8'h5a, 36'h0_0000_0000, 16'hffff, 3);
    endtask : sc_idle

    // Prints the counts and the verdict, then ends the run.
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : give_verdict

    // Resets the port, then runs every scenario.
    initial begin
        {clk, rst_n, single_clock, pll_bypass_n} = 4'h1;
        {e_q, s_q, sn_q} = 3'h0;
        {edges, cyc, n_mismatch, check_count} = '0;
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
        sc_fresh();
        sc_lanes();
        sc_idle();
        give_verdict();
    end
endmodule : burst4_ddr_sram_port_tb_top

// ### tb/burst4_port_checker.sv
// Pin level assertions for the burst SRAM port, bound to its top module.
`timescale 1ns/10ps

module burst4_port_checker (
    input logic              clk,
    input logic              rst_n,
    input logic              out_clk,
    input logic              out_clk_comp,
    input logic              single_clock,
    input logic              pll_bypass_n,
    input logic              read_port_sel_n,
    input burst4_pkg::word_t rdata,
    input logic              rdata_valid,
    input logic              returned_strobe,
    input logic              returned_strobe_n
);
    import burst4_pkg::*;
    logic [2:0] up_q;
    logic [5:0] idle_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // Counts cycles since reset release and since the last read select.
    always_ff @(posedge clk) begin
        up_q   <= !rst_n ? 3'h0 : up_q + {2'h0, up_q != 3'h4};
        idle_q <= (!rst_n) ? 6'h3f : (!read_port_sel_n) ? 6'h0 :
                  idle_q + {5'h0, idle_q != 6'h3f};
    end

    AST_RESET_QUIET: assert property ($rose(rst_n) |-> !rdata_valid &&
        rdata == '0 && !returned_strobe && !returned_strobe_n ##1 !rdata_valid)
        else $error("outputs busy after reset");
    AST_DATA_WITH_VALID: assert property ($changed(rdata) |-> rdata_valid)
        else $error("data changed without valid");
    AST_ECHO_TRUE: assert property (up_q == 3'h4 |->
        returned_strobe == $past(out_clk, 3)) else $error("echo true late");
    AST_ECHO_COMP: assert property (up_q == 3'h4 |->
        returned_strobe_n == $past(out_clk_comp, 3))
        else $error("echo complement late");
    AST_VALID_AT_EDGE: assert property ($rose(rdata_valid) |->
        $rose(returned_strobe) || $rose(returned_strobe_n))
        else $error("word started off an output edge");
    AST_VALID_ENDS_AT_EDGE: assert property ($fell(rdata_valid) |->
        $rose(returned_strobe) || $rose(returned_strobe_n))
        else $error("word ended off an output edge");
    AST_BURST_LENGTH: assert property ($rose(rdata_valid) |->
        rdata_valid [*8]) else $error("read burst cut short");
    AST_READ_CAUSED: assert property (rdata_valid |-> idle_q < 6'h28)
        else $error("read word without a read select");

    COV_PLL: cover property ($rose(rdata_valid) && pll_bypass_n);
    COV_BYPASS: cover property ($rose(rdata_valid) && !pll_bypass_n);
    COV_SINGLE: cover property ($rose(rdata_valid) && single_clock);
endmodule : burst4_port_checker

bind burst4_ddr_sram_port burst4_port_checker u_burst4_port_checker (
    .clk, .rst_n, .out_clk, .out_clk_comp, .single_clock, .pll_bypass_n,
    .read_port_sel_n, .rdata, .rdata_valid, .returned_strobe,
    .returned_strobe_n);

// ### tb/host_ctrl_model.sv
// Controller model driving the link clocks, addresses, selects and words.
`timescale 1ns/10ps

module host_ctrl_model (
    input  logic               clk,
    input  logic               rst_n,
    output logic               in_clk,
    output logic               in_clk_comp,
    output logic               out_clk,
    output logic               out_clk_comp,
    output burst4_pkg::addr_t  addr,
    output logic               read_port_sel_n,
    output logic               write_port_sel_n,
    output burst4_pkg::word_t  wdata,
    output burst4_pkg::lanes_t byte_write_sel_n
);
    import burst4_pkg::*;
    logic [3:0] wait_q;
    logic [2:0] ph_q;
    int         rises;
    int         rd_rise;

    // Pins start idle with both selects off.
    initial begin
        {in_clk, in_clk_comp, out_clk, out_clk_comp} = 4'h0;
        {read_port_sel_n, write_port_sel_n} = 2'h3;
        addr = '0;
        wdata = '0;
        byte_write_sel_n = 4'hf;
        rises = 0;
    end

    // The phase counter starts eight cycles after reset release.
    always @(posedge clk) begin
        wait_q <= !rst_n ? 4'h0 : wait_q + {3'h0, wait_q != 4'h8};
        ph_q   <= (wait_q == 4'h8) ? ph_q + 3'h1 : 3'h0;
    end

    // Input pair in antiphase at 80 ns; the output pair mirrors it.
    always @(negedge clk) begin
        in_clk       <= (wait_q == 4'h8) && !ph_q[2];
        in_clk_comp  <= (wait_q == 4'h8) && ph_q[2];
        out_clk      <= (wait_q == 4'h8) && !ph_q[2];
        out_clk_comp <= (wait_q == 4'h8) && ph_q[2];
        if (!rst_n) begin
            rises <= 0;
        end else if (wait_q == 4'h8 && ph_q == 3'h0) begin
            rises <= rises + 1;
        end
    end

    // Waits for the falling edge that starts the given phase.
    task automatic step(input logic [2:0] p);
        do @(negedge clk); while (ph_q != p);
    endtask : step

    // A write slot, then the next read slot; words on every pair rise.
    task automatic burst(input logic rd, input addr_t ra, input logic wr,
                         input addr_t wa, input word_t w[4],
                         input lanes_t ln[4]);
        do @(negedge clk); while (ph_q != 3'h6 || !rises[0]);
        addr             <= wa;
        write_port_sel_n <= !wr;
        for (int i = 0; i < 4; i++) begin
            step(i[0] ? 3'h6 : 3'h2);
            wdata            <= w[i];
            byte_write_sel_n <= ln[i];
            if (i == 1) begin
                addr            <= ra;
                read_port_sel_n <= !rd;
                rd_rise         = rises;
            end else if (i != 3) begin
                step(3'h4);
                addr             <= i == 0 ? ~wa : ~ra;
                write_port_sel_n <= 1'b1;
                read_port_sel_n  <= 1'b1;
            end
        end
        step(3'h2);
        wdata            <= ~w[3];
        byte_write_sel_n <= ~ln[3];
    endtask : burst
endmodule : host_ctrl_model
